// *** test/see_checker.sv ***
// port assertions for the serial eeprom engine
`timescale 1ns/1ps
module see_checker #(
	parameter int WRITE_CYCLES = 50
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// bus lines
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// pins and status
	input wire logic write_protect_input_i,
	input wire logic chip_strap_bit0_i,
	input wire logic chip_strap_bit1_i,
	input wire logic chip_strap_bit2_i,
	input wire logic write_busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [31:0] busy_cnt;
	// length of the running write cycle
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_cnt <= '0;
		end else begin
			busy_cnt <= write_busy_o ? busy_cnt + 32'h1 : '0;
		end
	end
	// both lines high, as after a stop
	sequence s_bus_idle;
		scl_i && sda_i;
	endsequence
	sequence s_held;
		sda_oe_o [*8];
	endsequence
	a_drain_low: assert property (sda_oe_o |-> !sda_o)
		else $error("data line driven high");
	a_busy_quiet: assert property (write_busy_o |-> !sda_oe_o)
		else $error("line driven during write cycle");
	a_cycle_on_stop: assert property ($rose(write_busy_o) |-> $past(scl_i, 4) ##0 s_bus_idle)
		else $error("write cycle without stop");
	a_busy_hold: assert property ($rose(write_busy_o) |=> write_busy_o [*8])
		else $error("write cycle too short");
	a_busy_max: assert property (write_busy_o |-> busy_cnt <= WRITE_CYCLES + 1)
		else $error("write cycle too long");
	a_busy_min: assert property ($fell(write_busy_o) |-> $past(busy_cnt) >= WRITE_CYCLES - 2)
		else $error("write cycle ended early");
	a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data changed while clock high");
	a_oe_held: assert property ($rose(sda_oe_o) |-> s_held)
		else $error("driven bit too short");
	a_idle_after: assert property ($fell(write_busy_o) |-> !sda_oe_o [*8])
		else $error("answer without new select");
endmodule
bind see_engine see_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.write_protect_input_i(write_protect_input_i), .chip_strap_bit0_i(chip_strap_bit0_i),
	.chip_strap_bit1_i(chip_strap_bit1_i), .chip_strap_bit2_i(chip_strap_bit2_i),
	.write_busy_o(write_busy_o));

// *** test/see_master.sv ***
// two-wire bus master model, open drain data
`timescale 1ns/1ps
module see_master #(
	parameter int Q = 8
) (
	// clock
	input wire logic clk_i,
	// bus lines
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// lines released at time zero
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick();
		repeat (Q) @(posedge clk_i);
	endtask
	// start or repeated start, clock left low
	task automatic start();
		sda_o <= 1'b1;
		tick();
		scl_o <= 1'b1;
		tick();
		sda_o <= 1'b0;
		tick();
		scl_o <= 1'b0;
		tick();
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		tick();
		scl_o <= 1'b1;
		tick();
		sda_o <= 1'b1;
		tick();
	endtask
	// data set while clock low, sampled mid high
	task automatic xbit(input logic b, output logic r);
		sda_o <= b;
		tick();
		scl_o <= 1'b1;
		tick();
		r = sda_i;
		tick();
		scl_o <= 1'b0;
		tick();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], r);
		end
		xbit(1'b1, r);
		ack = !r;
	endtask
	// last byte left unacknowledged
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xbit(1'b1, d[i]);
		end
		xbit(last, r);
	endtask
endmodule

// *** test/tb_top.sv ***
// testbench for the serial eeprom engine
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wp = 1'b0;
	logic [2:0] strap = 3'h5;
	logic scl, msda, sda_oe, sda_o, busy;
	wire logic sda = msda & ~sda_oe;
	int miscompares = 0;
	int n_tests = 0;
	always #20 clk_i = ~clk_i;
	see_master M (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(msda));
	see_engine #(.ADDR_W(9), .WRITE_CYCLES(50)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.write_protect_input_i(wp), .chip_strap_bit0_i(strap[0]),
		.chip_strap_bit1_i(strap[1]), .chip_strap_bit2_i(strap[2]), .write_busy_o(busy));
	task automatic close_out();
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// same upper seven bits for both selects of a read
	function automatic logic [7:0] sel(input logic [8:0] a, input logic rw);
		return {see_pkg::DEV_TYPE_DEFAULT, 2'b10, a[8], rw};
	endfunction
	task automatic see_busy(output logic k);
		k = 1'b0;
		repeat (24) begin
			@(posedge clk_i);
			k = k | busy;
		end
	endtask
	task automatic wr(input logic [8:0] a, input int n, input logic [7:0] d0, input logic ok);
		logic k;
		M.start();
		M.wbyte(sel(a, 1'b0), k);
		check({7'h0, k}, 8'h01);
		M.wbyte(a[7:0], k);
		check({7'h0, k}, 8'h01);
		for (int i = 0; i < n; i++) begin
			M.wbyte(d0 + 8'(i * 17), k);
			check({7'h0, k}, {7'h0, ok});
		end
		M.stop();
		see_busy(k);
		check({7'h0, k}, {7'h0, ok});
		if (ok) begin
			M.start();
			M.wbyte(sel(a, 1'b0), k);
			check({7'h0, k}, 8'h00);
			M.stop();
			M.start();
			M.wbyte(sel(a, 1'b0), k);
			check({7'h0, k}, 8'h01);
			M.stop();
		end
	endtask
	task automatic rd(input logic [8:0] a, input int n, input logic [31:0] e);
		logic k;
		logic [7:0] d;
		M.start();
		M.wbyte(sel(a, 1'b0), k);
		M.wbyte(a[7:0], k);
		M.start();
		M.wbyte(sel(a, 1'b1), k);
		check({7'h0, k}, 8'h01);
		for (int i = 0; i < n; i++) begin
			M.rbyte(i == n - 1, d);
			check(d, e[31 - 8 * i -: 8]);
		end
		check({7'h0, sda_oe}, 8'h00);
		M.stop();
	endtask
	task automatic cur(input logic [7:0] exp);
		logic k;
		logic [7:0] d;
		M.start();
		M.wbyte(sel(9'h000, 1'b1), k);
		check({7'h0, k}, 8'h01);
		M.rbyte(1'b1, d);
		check(d, exp);
		M.stop();
	endtask
	// stop in mid byte after one accepted byte
	task automatic midstop();
		logic k;
		M.start();
		M.wbyte(sel(9'h040, 1'b0), k);
		M.wbyte(8'h40, k);
		M.wbyte(8'h77, k);
		for (int i = 0; i < 4; i++) begin
			M.xbit(1'b0, k);
		end
		M.stop();
		see_busy(k);
		check({7'h0, k}, 8'h00);
	endtask
	task automatic strap_miss();
		logic k;
		M.start();
		M.wbyte({see_pkg::DEV_TYPE_DEFAULT, 4'h5}, k);
		check({7'h0, k}, 8'h00);
		M.stop();
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge clk_i);
		miscompares++;
		close_out();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		cur(8'hff);
		wp <= 1'b1;
		wr(9'h030, 1, 8'h5a, 1'b0);
		wp <= 1'b0;
		wr(9'h01e, 3, 8'ha1, 1'b1);
		wr(9'h000, 1, 8'h3c, 1'b1);
		midstop();
		wp <= 1'b1;
		rd(9'h01e, 3, 32'ha1b2ff00);
		rd(9'h010, 1, 32'hc3000000);
		rd(9'h1ff, 2, 32'hff3c0000);
		rd(9'h030, 1, 32'hff000000);
		rd(9'h040, 1, 32'hff000000);
		rd(9'h01e, 1, 32'ha1000000);
		cur(8'hb2);
		strap_miss();
		close_out();
	end
endmodule

// *** verilog/see_engine.sv ***
// two-wire serial eeprom slave: command engine, page buffer and array
// Summary of operation
// R1 - write: select with direction 0 acked, address byte acked, then data bytes
// R2 - stop in the slot right after a data ack starts the write cycle
// R3 - stop in any other slot never starts the write cycle
// R4 - during the write cycle both bus lines are ignored, nothing answers
// R5 - protect high from start to address end: data refused, location untouched
// R6 - unprotected byte write: the data byte is acked, master then stops
// R7 - page write stores up to sixteen bytes of one page per cycle
// R8 - master must not overrun the page end; excess wraps inside the page
// R9 - page write of one to sixteen bytes, all acked, or all refused if protected
// R10 - write counter increments only its low four bits
// R11 - select during write cycle gets no ack; acked again once done
// R12 - random read repeats the same upper seven select bits
// R13 - reads behave the same whatever the protect level
// R14 - random read: dummy write, repeated start, read select, one byte, no ack
// R15 - current read: ack select, send byte at counter, then increment counter
// R16 - sequential read: each master ack brings the next byte
// R17 - read counter wraps from the top address to 00h
// R18 - master leaving ninth slot high ends the read, back to standby
// R19 - the array starts with every byte at FFh
// R20 - select acked only when strap field matches; larger arrays use address bits
// R21 - last select bit: 1 read, 0 write
// R22 - address width and write cycle length are parameters
// R23 - page data latched in a sixteen-byte buffer, committed at cycle start
`timescale 1ns/1ps
module see_engine #(
	parameter int ADDR_W = see_pkg::ADDR_W_DEFAULT, // R22
	parameter int WRITE_CYCLES = see_pkg::INTERNAL_WRITE_CYCLES, // R22
	parameter logic [3:0] DEV_TYPE = see_pkg::DEV_TYPE_DEFAULT
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// serial clock and data lines (data is open drain)
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// protect and strap pins
	input wire logic write_protect_input_i,
	input wire logic chip_strap_bit0_i,
	input wire logic chip_strap_bit1_i,
	input wire logic chip_strap_bit2_i,
	// status
	output logic write_busy_o
);
	localparam int UP_W = (ADDR_W > 8) ? ADDR_W - 8 : 0;
	localparam logic [2:0] STRAP_MASK = 3'(3'h7 << UP_W);
	localparam int DEPTH = 1 << ADDR_W;

	// synchronised pins
	logic scl_q;
	logic sda_q;
	logic wp_q;
	logic [2:0] strap_q;
	logic scl_d;
	logic sda_d;

	// engine state
	see_pkg::see_state_t state;
	logic [3:0] cnt;
	logic [7:0] rx;
	logic [7:0] tx;
	logic in_ack;
	logic rw;
	logic [ADDR_W-1:0] addr;
	logic [2:0] sel_hold;
	logic wp_seen;
	logic after_ack;
	logic wrote;
	logic [31:0] wcnt;
	logic [7:0] page_buf [see_pkg::PAGE_BYTES];
	logic [see_pkg::PAGE_BYTES-1:0] page_valid;
	logic [7:0] mem [DEPTH];

	see_sync #(.WIDTH(1), .INIT(1'b1)) u_scl (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(scl_i),
		.level_o(scl_q)
	);
	see_sync #(.WIDTH(1), .INIT(1'b1)) u_sda (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(sda_i),
		.level_o(sda_q)
	);
	see_sync #(.WIDTH(1), .INIT(1'b0)) u_wp (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(write_protect_input_i),
		.level_o(wp_q)
	);
	see_sync #(.WIDTH(3), .INIT(3'h0)) u_strap (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i({chip_strap_bit2_i, chip_strap_bit1_i, chip_strap_bit0_i}),
		.level_o(strap_q)
	);

	// line edges and bus conditions
	wire scl_rise = scl_q & ~scl_d;
	wire scl_fall = ~scl_q & scl_d;
	wire start_cond = scl_q & scl_d & sda_d & ~sda_q;
	wire stop_cond = scl_q & scl_d & ~sda_d & sda_q;

	// select byte decode: type, strap field, upper address bits
	wire [2:0] sel_up = rx[3:1] & ~STRAP_MASK; // R20
	wire strap_ok = ((rx[3:1] ^ strap_q) & STRAP_MASK) == 3'h0; // R20
	wire sel_match = (rx[7:4] == DEV_TYPE) && strap_ok;
	wire sel_read = rx[0]; // R21

	// address loading and stepping
	wire [see_pkg::FULL_ADDR_W-1:0] addr_ext = see_pkg::FULL_ADDR_W'(addr);
	wire [see_pkg::FULL_ADDR_W-1:0] wr_full = {sel_hold, rx};
	wire [see_pkg::FULL_ADDR_W-1:0] rd_full = {sel_up, addr_ext[7:0]};
	wire [ADDR_W-1:0] page_step = {addr[ADDR_W-1:see_pkg::PAGE_BITS],
		addr[see_pkg::PAGE_BITS-1:0] + 4'h1}; // R10
	wire [ADDR_W-1:0] seq_step = addr + ADDR_W'(1); // R17
	wire [see_pkg::PAGE_BITS-1:0] slot = addr[see_pkg::PAGE_BITS-1:0];
	wire [7:0] mem_rd = mem[addr];

	// write cycle launch: only a stop in the slot after a data ack
	wire commit = stop_cond && after_ack && wrote && (state == see_pkg::ST_WDATA); // R2 R3
	wire cycle_done = (state == see_pkg::ST_WCYCLE) && (wcnt == 32'h1);

	// previous line levels for edge detection
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_q;
			sda_d <= sda_q;
		end
	end

	// bus engine
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= see_pkg::ST_IDLE;
			cnt <= see_pkg::BIT_FIRST;
			rx <= 8'h00;
			tx <= 8'h00;
			in_ack <= 1'b0;
			rw <= 1'b0;
			addr <= '0;
			sel_hold <= 3'h0;
			wp_seen <= 1'b0;
			after_ack <= 1'b0;
			wrote <= 1'b0;
			wcnt <= 32'h0;
			sda_oe_o <= 1'b0;
			page_valid <= '0;
			for (int i = 0; i < see_pkg::PAGE_BYTES; i++) begin
				page_buf[i] <= 8'h00;
			end
		end else if (state == see_pkg::ST_WCYCLE) begin
			// bus fully ignored while the array is written
			sda_oe_o <= 1'b0; // R4
			wcnt <= wcnt - 32'h1;
			if (cycle_done) begin
				state <= see_pkg::ST_IDLE; // R11
			end
		end else if (start_cond) begin
			// start or repeated start: fresh select byte
			state <= see_pkg::ST_SELECT;
			cnt <= see_pkg::BIT_FIRST;
			in_ack <= 1'b0;
			sda_oe_o <= 1'b0;
			wp_seen <= wp_q; // R5
			wrote <= 1'b0;
			after_ack <= 1'b0;
			page_valid <= '0;
		end else if (stop_cond) begin
			sda_oe_o <= 1'b0;
			in_ack <= 1'b0;
			after_ack <= 1'b0;
			if (commit) begin
				state <= see_pkg::ST_WCYCLE; // R2
				wcnt <= 32'(WRITE_CYCLES);
			end else begin
				state <= see_pkg::ST_IDLE; // R3
			end
		end else begin
			unique case (state)
				see_pkg::ST_IDLE: begin
					sda_oe_o <= 1'b0;
				end
				see_pkg::ST_SELECT, see_pkg::ST_ADDR, see_pkg::ST_WDATA: begin
					// protect level is watched up to the end of the address byte
					if (state != see_pkg::ST_WDATA) begin
						wp_seen <= wp_seen | wp_q; // R5
					end
					// the slot after a data ack stays open until the next clock fall
					if (scl_fall) begin
						after_ack <= 1'b0; // R3
					end
					if (scl_rise) begin
						if (cnt < see_pkg::BIT_LAST) begin
							rx <= {rx[6:0], sda_q};
							cnt <= cnt + 4'h1;
						end
					end
					if (scl_fall && cnt == see_pkg::BIT_LAST && !in_ack) begin
						// byte complete: decide the ack for the ninth slot
						in_ack <= 1'b1;
						unique case (state)
							see_pkg::ST_SELECT: begin
								sel_hold <= sel_up;
								rw <= sel_read; // R21
								sda_oe_o <= sel_match; // R1 R20
								if (!sel_match) begin
									state <= see_pkg::ST_IDLE;
								end else if (sel_read) begin
									addr <= rd_full[ADDR_W-1:0]; // R12
								end
							end
							see_pkg::ST_ADDR: begin
								sda_oe_o <= 1'b1; // R1
								addr <= wr_full[ADDR_W-1:0];
							end
							default: begin
								// data byte: refused when protected
								sda_oe_o <= ~wp_seen; // R5 R6 R9
								if (!wp_seen) begin
									page_buf[slot] <= rx; // R23
									page_valid[slot] <= 1'b1; // R7 R8
									addr <= page_step; // R10
									wrote <= 1'b1;
								end
							end
						endcase
					end else if (scl_fall && in_ack) begin
						// ack slot over: release and move on
						in_ack <= 1'b0;
						cnt <= see_pkg::BIT_FIRST;
						sda_oe_o <= 1'b0;
						if (state == see_pkg::ST_SELECT && rw) begin
							state <= see_pkg::ST_RDATA; // R13 R14 R15
							tx <= mem_rd;
							sda_oe_o <= ~mem_rd[7];
						end else if (state == see_pkg::ST_SELECT) begin
							state <= see_pkg::ST_ADDR; // R1
						end else if (state == see_pkg::ST_ADDR) begin
							state <= see_pkg::ST_WDATA; // R1
						end else begin
							after_ack <= sda_oe_o; // R2
						end
					end
				end
				see_pkg::ST_RDATA: begin
					if (scl_rise) begin
						if (cnt < see_pkg::BIT_LAST) begin
							cnt <= cnt + 4'h1;
						end else if (cnt == see_pkg::BIT_LAST) begin
							// master answer in the ninth slot
							if (sda_q) begin
								state <= see_pkg::ST_IDLE; // R18
							end else begin
								tx <= mem_rd; // R16
								cnt <= see_pkg::BIT_RELOAD;
							end
						end
					end
					if (scl_fall) begin
						if (cnt == see_pkg::BIT_LAST) begin
							sda_oe_o <= 1'b0;
							addr <= seq_step; // R15 R17
						end else if (cnt == see_pkg::BIT_RELOAD) begin
							cnt <= see_pkg::BIT_FIRST;
							sda_oe_o <= ~tx[7]; // R16
						end else if (cnt != see_pkg::BIT_FIRST) begin
							tx <= {tx[6:0], 1'b0};
							sda_oe_o <= ~tx[6];
						end
					end
				end
				default: begin
					state <= see_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// array: erased after reset, page committed when the cycle starts
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= see_pkg::ERASED_BYTE; // R19
			end
		end else if (commit) begin
			for (int i = 0; i < see_pkg::PAGE_BYTES; i++) begin
				if (page_valid[i]) begin
					mem[{addr[ADDR_W-1:see_pkg::PAGE_BITS], 4'(i)}] <= page_buf[i]; // R7 R23
				end
			end
		end
	end

	// data pin only ever pulls low; busy flag for the outside
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sda_o <= 1'b0;
			write_busy_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			write_busy_o <= (state == see_pkg::ST_WCYCLE); // R11
		end
	end
endmodule

// *** verilog/see_pkg.sv ***
// shared constants and types of the serial eeprom engine
package see_pkg;
	// system clock
	localparam int CLK_PERIOD_NS = 40;
	// self-timed internal write duration and its cycle count, rounded up
	localparam int INTERNAL_WRITE_TIME_NS = 5000000;
	localparam int INTERNAL_WRITE_CYCLES =
		(INTERNAL_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// array geometry
	localparam int ADDR_W_DEFAULT = 11;
	localparam int PAGE_BYTES = 16;
	localparam int PAGE_BITS = 4;
	localparam int SEL_UP_W = 3;
	localparam int FULL_ADDR_W = 11;
	// erased cell contents after reset
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// device type nibble of the select byte; the value is arbitrary
	localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
	// bit slot counts within a byte
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_RELOAD = 4'h9;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	// bus engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SELECT,
		ST_ADDR,
		ST_WDATA,
		ST_RDATA,
		ST_WCYCLE
	} see_state_t;
endpackage

// *** verilog/see_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module see_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// asynchronous pin level and its filtered copy
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

	// shift chain; level follows a bit once stages two and three agree
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			level_o <= INIT;
		end else begin
			stage1 <= pin_i;
			stage2 <= stage1;
			stage3 <= stage2;
			level_o <= (stage3 & agree) | (level_o & ~agree);
		end
	end
endmodule
